//--- design/serirq_req_ctrl.sv
// Host serial interrupt request controller with its pin output stage.
//
// Decided for this implementation: the address map and strobed register access.
`default_nettype none
`include "serirq_req_params.svh"
module serirq_req_ctrl (
  input  wire logic                        mclk,
  input  wire logic                        nrst,
  input  wire serirq_req_pkg::bus_req_type bus,
  output logic [7:0]                       rdata,
  input  wire logic                        ch2_out_full,
  input  wire logic                        uart_irq,
  input  wire logic                        two_way_reg_mode,
  input  wire logic                        lpc_hw_rst_n,
  input  wire logic                        lpc_sw_rst,
  output logic [7:0]                       ch3_out_data,
  output logic                             ch3_out_full_a,
  output logic                             status3_user_mode,
  output logic [15:0]                      frame_req,
  input  wire logic                        lclk,
  input  wire logic                        lrst_n,
  input  wire logic                        host_rd_ch3,
  input  wire logic                        frame_active,
  input  wire logic [3:0]                  frame_num,
  output logic                             serirq_out,
  output logic                             serirq_oe_n
);

  // ****************************************************************
  // Reset values and local signals
  // ****************************************************************

  localparam serirq_req_pkg::core_type CORE_RST = '{
    ch23_en:    `RST_ZERO,
    arm:        `RST_ZERO,
    ch3_dir:    `RST_ZERO,
    uart_sel:   `RST_ZERO,
    misc_en:    `RST_MISC_EN,
    pol_a:      `RST_ZERO,
    host_if_function_select:      `RST_HOST_IF_FUNCTION_SELECT,
    ch2_dir:    `RST_ZERO,
    ch3_data:   `RST_ZERO,
    rdata:      `RST_ZERO,
    ch3_full:   1'b0,
    ch2_full_q: 1'b0,
    ack_q:      1'b0,
    user_nib:   1'b0,
    req:        16'h0000,
    drive:      16'h0000
  };

  localparam serirq_req_pkg::link_type LINK_RST = '{
    rd_tgl: 1'b0,
    oe_n:   1'b1
  };

  serirq_req_pkg::core_type c_reg;
  serirq_req_pkg::core_type c_next;
  serirq_req_pkg::link_type l_reg;
  serirq_req_pkg::link_type l_next;

  logic [1:0]  lpc_rst_s;
  logic        ack_s;
  logic [15:0] drive_s;
  logic        lpc_rst;
  logic        host_rd_evt;
  logic        ch3_wr;
  logic        ch3_clr;
  logic        ch2_fall;
  logic        dir3;
  logic        dir2;
  logic        ch3_gate;
  logic        ch2_gate;
  logic [7:0]  en;
  logic [15:0] req;
  logic [15:0] pol;

  // ****************************************************************
  // Domain crossings
  // ****************************************************************

  // LPC reset pins come from the host side and are synchronised first.
  sync2 #(
    .WIDTH (2)
  ) u_rst_sync (
    .clk   (mclk),
    .rst_n (nrst),
    .d     ({~lpc_hw_rst_n, lpc_sw_rst}),
    .q     (lpc_rst_s)
  );

  // Host reads of the channel 3 data travel as a toggle.
  sync2 #(
    .WIDTH (1)
  ) u_ack_sync (
    .clk   (mclk),
    .rst_n (nrst),
    .d     (l_reg.rd_tgl),
    .q     (ack_s)
  );

  // A change of several bits may land one link clock apart. The host
  // samples each frame in its own slot, so a one-slot skew is harmless.
  // A word that had to arrive whole would need a handshake instead.
  // Each pin drive bit is an independent level, so bitwise sync is safe.
  sync2 #(
    .WIDTH (`FR_COUNT)
  ) u_drive_sync (
    .clk   (lclk),
    .rst_n (lrst_n),
    .d     (c_reg.drive),
    .q     (drive_s)
  );

  // ****************************************************************
  // Register side, on-chip clock
  // ****************************************************************

  // The toggle compare sees one event per host read only while reads are
  // more than one on-chip clock apart; closer reads can cancel in pairs and be lost.
  // Event decode for the flags and the enable clearing.
  always_comb
  begin
    lpc_rst     = lpc_rst_s[1] | lpc_rst_s[0];
    host_rd_evt = ack_s ^ c_reg.ack_q;
    ch3_wr      = bus.wr && (bus.addr == `ADDR_CH3_DATA);
    dir3        = c_reg.ch3_dir[`BIT_DIRECT];
    dir2        = c_reg.ch2_dir[`BIT_DIRECT];
    // A data write in the same cycle as a host read keeps the flag set.
    ch3_clr     = host_rd_evt & c_reg.ch3_full & ~ch3_wr;
    ch2_fall    = c_reg.ch2_full_q & ~ch2_out_full;
  end

  // Gating uses the live channel 2 flag so that a request drops with it.
  // The channel 3 flag is local and already registered.
  // Source gating and frame mapping; sources of one frame are ORed.
  always_comb
  begin
    ch3_gate = dir3 | c_reg.ch3_full;
    ch2_gate = dir2 | ch2_out_full;
    req      = 16'h0000;
    req[`FR_11] = (c_reg.ch23_en[7] & ch3_gate)
                | (c_reg.ch23_en[3] & ch2_gate);
    req[`FR_10] = (c_reg.ch23_en[6] & ch3_gate)
                | (c_reg.ch23_en[2] & ch2_gate);
    req[`FR_9]  = (c_reg.ch23_en[5] & ch3_gate)
                | (c_reg.ch23_en[1] & ch2_gate);
    req[`FR_6]  = (c_reg.ch23_en[4] & ch3_gate)
                | (c_reg.ch23_en[0] & ch2_gate);
    req[15] = c_reg.misc_en[7];
    req[14] = c_reg.misc_en[6];
    req[13] = c_reg.misc_en[5];
    req[8]  = c_reg.misc_en[4];
    req[7]  = c_reg.misc_en[3];
    req[5]  = c_reg.misc_en[2];
    req[4]  = c_reg.misc_en[1];
    req[3]  = c_reg.misc_en[0];
    // Code zero means no request; frame 0 is never driven.
    if (uart_irq && (c_reg.uart_sel[3:0] != 4'h0))
    begin
      req[c_reg.uart_sel[3:0]] = 1'b1;
    end
  end

  // Frames 12 and 1 reset to inverted polarity, so after reset their
  // slots are pulled low until a request arrives.
  // Per-frame polarity; a 1 in the drive vector pulls the pin low.
  always_comb
  begin
    pol         = 16'h0000;
    pol[15]     = c_reg.pol_a[7];
    pol[14]     = c_reg.pol_a[6];
    pol[13]     = c_reg.pol_a[5];
    pol[8]      = c_reg.pol_a[4];
    pol[7]      = c_reg.pol_a[3];
    pol[5]      = c_reg.pol_a[2];
    pol[4]      = c_reg.pol_a[1];
    pol[3]      = c_reg.pol_a[0];
    pol[`FR_11] = c_reg.host_if_function_select[6];
    pol[`FR_10] = c_reg.host_if_function_select[5];
    pol[`FR_9]  = c_reg.host_if_function_select[4];
    pol[`FR_6]  = c_reg.host_if_function_select[3];
    pol[`FR_MGMT] = c_reg.host_if_function_select[2];
    pol[12]     = c_reg.host_if_function_select[1];
    pol[1]      = c_reg.host_if_function_select[0];
  end

  // Priority inside one cycle, lowest first: flag-drop clearing, then
  // register writes (an armed 1 wins over the clear), then the LPC
  // resets, which override everything on the enables and the flag.
  // Next state of the register side.
  always_comb
  begin
    c_next            = c_reg;
    c_next.rdata      = `RST_ZERO;
    c_next.ch2_full_q = ch2_out_full;
    c_next.ack_q      = ack_s;
    c_next.req        = req;
    c_next.drive      = req ^ pol;
    c_next.user_nib   = c_reg.host_if_function_select[`BIT_SEL_CH3_STATUS_REG]
                      & ~two_way_reg_mode;

    // Output-full flag of channel 3; set wins over the host read.
    if (ch3_wr)
    begin
      c_next.ch3_full = 1'b1;
    end
    else if (ch3_clr)
    begin
      c_next.ch3_full = 1'b0;
    end

    // Enables drop with their flag unless direct mode holds them.
    en = c_reg.ch23_en;
    if (ch3_clr && !dir3)
    begin
      en[7:4] = 4'h0;
    end
    if (ch2_fall && !dir2)
    begin
      en[3:0] = 4'h0;
    end

    // Register writes; only this port reaches the control bits.
    if (bus.wr)
    begin
      unique case (bus.addr)
        `ADDR_CH23_EN:
        begin
          // A 0 clears; a 1 sets only a bit that was read back as 0.
          en = (en & bus.wdata)
             | (bus.wdata & c_reg.arm);
          c_next.arm = `RST_ZERO;
        end
        `ADDR_CH3_DIR:  c_next.ch3_dir  = bus.wdata;
        `ADDR_UART_SEL: c_next.uart_sel = bus.wdata;
        `ADDR_MISC_EN:  c_next.misc_en  = bus.wdata;
        `ADDR_POL_A:    c_next.pol_a    = bus.wdata;
        `ADDR_HOST_IF_FUNCTION_SELECT:    c_next.host_if_function_select    = bus.wdata;
        `ADDR_CH2_DIR:  c_next.ch2_dir  = bus.wdata;
        `ADDR_CH3_DATA: c_next.ch3_data = bus.wdata;
        default:
        begin
          c_next.arm = c_reg.arm;
        end
      endcase
    end

    // Register reads; an unmapped address reads as zero.
    if (bus.rd)
    begin
      unique case (bus.addr)
        `ADDR_CH23_EN:
        begin
          c_next.rdata = c_reg.ch23_en;
          c_next.arm   = ~c_reg.ch23_en;
        end
        `ADDR_CH3_DIR:  c_next.rdata = c_reg.ch3_dir;
        `ADDR_UART_SEL: c_next.rdata = c_reg.uart_sel;
        `ADDR_MISC_EN:  c_next.rdata = c_reg.misc_en;
        `ADDR_POL_A:    c_next.rdata = c_reg.pol_a;
        `ADDR_HOST_IF_FUNCTION_SELECT:    c_next.rdata = c_reg.host_if_function_select;
        `ADDR_CH2_DIR:  c_next.rdata = c_reg.ch2_dir;
        `ADDR_CH3_DATA: c_next.rdata = c_reg.ch3_data;
        `ADDR_STATUS:
        begin
          c_next.rdata[`ST_CH3_FULL] = c_reg.ch3_full;
          c_next.rdata[`ST_CH2_FULL] = c_reg.ch2_full_q;
          c_next.rdata[`ST_LPC_RST]  = lpc_rst;
          c_next.rdata[`ST_USER_NIB] = c_reg.user_nib;
        end
        default:
        begin
          c_next.rdata = `RST_ZERO;
        end
      endcase
    end

    // LPC resets override everything on the channel enables and flag.
    if (lpc_rst)
    begin
      en              = `RST_ZERO;
      c_next.arm      = `RST_ZERO;
      c_next.ch3_full = 1'b0;
    end
    c_next.ch23_en = en;
  end

  // Reset is synchronous: the clock must run while it is held, at least
  // one edge, which also loads constants into both synchroniser stages.
  // Register stage of the on-chip domain.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      c_reg <= CORE_RST;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  // Every output comes straight from a flop, so none of them glitches.
  assign rdata             = c_reg.rdata;
  assign ch3_out_data      = c_reg.ch3_data;
  assign ch3_out_full_a    = c_reg.ch3_full;
  assign status3_user_mode = c_reg.user_nib;
  assign frame_req         = c_reg.req;

  // ****************************************************************
  // Link side, LPC clock
  // ****************************************************************

  // The pin stage is one flop behind the slot inputs: the host names a
  // slot on one edge and sees the pin from the next edge on.
  // The data byte is quasi-static to the host: the flag tells it when.
  always_comb
  begin
    l_next        = l_reg;
    l_next.rd_tgl = l_reg.rd_tgl ^ host_rd_ch3;
    // Drive low only in the active slot of a frame whose bit asks it.
    l_next.oe_n   = ~(frame_active & drive_s[frame_num]);
  end

  // Register stage of the link domain.
  always_ff @(posedge lclk)
  begin
    if (!lrst_n)
    begin
      l_reg <= LINK_RST;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // No level is ever driven high: the line is open drain with a pull-up.
  // The pin only ever pulls low; the enable decides.
  assign serirq_out  = 1'b0;
  assign serirq_oe_n = l_reg.oe_n;

endmodule
`default_nettype wire

//--- design/serirq_req_params.svh
// Offsets, field positions, reset values and frame numbers of the block.
`ifndef SERIRQ_REQ_PARAMS_SVH
`define SERIRQ_REQ_PARAMS_SVH

// Register offsets on the on-chip port.
`define ADDR_CH23_EN   4'h0
`define ADDR_CH3_DIR   4'h1
`define ADDR_UART_SEL  4'h2
`define ADDR_MISC_EN   4'h3
`define ADDR_POL_A     4'h4
`define ADDR_HOST_IF_FUNCTION_SELECT     4'h5
`define ADDR_CH2_DIR   4'h6
`define ADDR_CH3_DATA  4'h7
`define ADDR_STATUS    4'h8

// Reset values.
`define RST_ZERO       8'h00
`define RST_MISC_EN    8'h03
`define RST_HOST_IF_FUNCTION_SELECT      8'h03

// Field positions.
`define BIT_DIRECT     7
`define BIT_SEL_CH3_STATUS_REG   7
`define ST_CH3_FULL    0
`define ST_CH2_FULL    1
`define ST_LPC_RST     2
`define ST_USER_NIB    3

// Frame numbers; frame 2 carries the system management request.
`define FR_MGMT        2
`define FR_6           6
`define FR_9           9
`define FR_10          10
`define FR_11          11
`define FR_COUNT       16
`endif

//--- design/serirq_req_pkg.sv
// Types shared by the serial interrupt request controller.
`default_nettype none
package serirq_req_pkg;

  // One request on the on-chip register port.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  // State of the on-chip clock domain.
  typedef struct packed {
    logic [7:0]  ch23_en;
    logic [7:0]  arm;
    logic [7:0]  ch3_dir;
    logic [7:0]  uart_sel;
    logic [7:0]  misc_en;
    logic [7:0]  pol_a;
    logic [7:0]  host_if_function_select;
    logic [7:0]  ch2_dir;
    logic [7:0]  ch3_data;
    logic [7:0]  rdata;
    logic        ch3_full;
    logic        ch2_full_q;
    logic        ack_q;
    logic        user_nib;
    logic [15:0] req;
    logic [15:0] drive;
  } core_type;

  // State of the link clock domain.
  typedef struct packed {
    logic rd_tgl;
    logic oe_n;
  } link_type;

endpackage
`default_nettype wire

//--- design/sync2.sv
// Two flip-flop level synchroniser of parameterised width.
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_type;

  sync_type s_reg;
  sync_type s_next;

  // The first stage feeds only the second; nothing else looks at it.
  always_comb
  begin
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  // Synchronous reset to constants.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule
`default_nettype wire

//--- tb/serirq_req_ctrl_properties.sv
// Port-level concurrent checks of the serial interrupt request controller.
`default_nettype none
module serirq_req_ctrl_properties (
  input wire logic                        mclk,
  input wire logic                        nrst,
  input wire serirq_req_pkg::bus_req_type bus,
  input wire logic [7:0]                  rdata,
  input wire logic                        two_way_reg_mode,
  input wire logic                        lpc_hw_rst_n,
  input wire logic                        lpc_sw_rst,
  input wire logic                        ch3_out_full_a,
  input wire logic                        status3_user_mode,
  input wire logic [15:0]                 frame_req,
  input wire logic                        lclk,
  input wire logic                        lrst_n,
  input wire logic                        frame_active,
  input wire logic                        serirq_out,
  input wire logic                        serirq_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Sequences
  // ****************************************
  // Four samples cover the two-flop reset synchroniser and its register.
  sequence s_lpc_busy;
    (!lpc_hw_rst_n || lpc_sw_rst) [*4];
  endsequence
  sequence s_lpc_quiet;
    (lpc_hw_rst_n && !lpc_sw_rst) [*4];
  endsequence
  sequence s_data_write;
    bus.wr && bus.addr == 4'h7;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  // Register port answers.
  a_flag_on_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_lpc_quiet ##0 s_data_write |=> ch3_out_full_a)
    else $error("flag did not set after a data write");
  a_status_flag: assert property (
    @(posedge mclk) disable iff (!nrst)
    bus.rd && bus.addr == 4'h8 |=> rdata[0] == $past(ch3_out_full_a))
    else $error("status bit 0 differs from the flag");
  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    bus.rd && bus.addr > 4'h8 |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  a_rdata_idle: assert property (
    @(posedge mclk) disable iff (!nrst)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data stood without a read");
  // Reset and mode effects.
  a_reset_frames: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(nrst) |=> frame_req == 16'h0018)
    else $error("frame requests wrong after reset");
  a_lpc_reset_flag: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_lpc_busy |=> !ch3_out_full_a)
    else $error("flag survived an LPC reset");
  a_user_bits: assert property (
    @(posedge mclk) disable iff (!nrst)
    two_way_reg_mode [*3] |-> !status3_user_mode)
    else $error("user nibble granted in two-way mode");
  // Pin stage in the link domain.
  a_pin_idle: assert property (
    @(posedge lclk) disable iff (!lrst_n)
    !frame_active |=> serirq_oe_n)
    else $error("pin driven outside a frame slot");
  a_pin_low: assert property (
    @(posedge lclk) disable iff (!lrst_n)
    !serirq_oe_n |-> !serirq_out && $past(frame_active))
    else $error("pin driven high");
endmodule

bind serirq_req_ctrl serirq_req_ctrl_properties u_props (
  .mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
  .two_way_reg_mode(two_way_reg_mode), .lpc_hw_rst_n(lpc_hw_rst_n),
  .lpc_sw_rst(lpc_sw_rst), .ch3_out_full_a(ch3_out_full_a),
  .status3_user_mode(status3_user_mode), .frame_req(frame_req),
  .lclk(lclk), .lrst_n(lrst_n), .frame_active(frame_active),
  .serirq_out(serirq_out), .serirq_oe_n(serirq_oe_n));
`default_nettype wire

//--- tb/lpc_host_model.sv
// Behavioural LPC host: pulses data reads and samples interrupt frames.
`default_nettype none
module lpc_host_model (
  input  wire logic  lclk,
  input  wire logic  sirq_pin,
  output logic       host_rd_ch3,
  output logic       frame_active,
  output logic [3:0] frame_num
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] seen;

  // Idle lines; the frame number is scrambled outside its slot.
  initial
  begin
    host_rd_ch3  = 1'b0;
    frame_active = 1'b0;
    frame_num    = 4'hF;
  end

  // One host read of the channel 3 data is a single-clock pulse.
  task automatic host_read();
    @(posedge lclk);
    host_rd_ch3 <= 1'b1;
    @(posedge lclk);
    host_rd_ch3 <= 1'b0;
  endtask

  // Walk frames 0 to 15; a low pin one clock later means the frame is driven, which for an inverted frame means no request.
  task automatic scan();
    for (int n = 0; n < 16; n++)
    begin
      @(posedge lclk);
      frame_active <= 1'b1;
      frame_num    <= 4'(n);
      @(posedge lclk);
      frame_active <= 1'b0;
      frame_num    <= ~4'(n);
      @(posedge lclk);
      seen[n] = !sirq_pin;
    end
  endtask
endmodule
`default_nettype wire

//--- tb/serirq_req_ctrl_tb.sv
// Self-checking bench of the serial interrupt request controller.
`default_nettype none
module serirq_req_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        mclk = 1'b0;
  logic                        lclk = 1'b0;
  logic                        nrst = 1'b0;
  logic                        lrst_n = 1'b0;
  serirq_req_pkg::bus_req_type bus = '0;
  logic                        ch2_out_full = 1'b0;
  logic                        uart_irq = 1'b0;
  logic                        two_way_reg_mode = 1'b0;
  logic                        lpc_hw_rst_n = 1'b1;
  logic                        lpc_sw_rst = 1'b0;
  logic [7:0]                  rdata;
  logic [7:0]                  ch3_out_data;
  logic                        ch3_out_full_a;
  logic                        status3_user_mode;
  logic [15:0]                 frame_req;
  logic                        host_rd_ch3;
  logic                        frame_active;
  logic [3:0]                  frame_num;
  logic                        serirq_out;
  logic                        serirq_oe_n;
  wire logic                   sirq_pin;
  int                          err_count = 0;
  int                          check_count = 0;
  int                          seed = 32'h73db_51e2;
  logic [31:0]                 r;
  logic [7:0]                  q;
  logic [7:0]                  e8;
  logic                        lpcr = 1'b0;
  logic [7:0]                  arm = 8'h00;
  logic                        full3 = 1'b0;
  logic [7:0]                  mr [16] = '{3: 8'h03, 5: 8'h03, default: 0};

  // ****************************************
  // Clocks, pin and instances
  // ****************************************
  // Rising edges of the two clocks never coincide.
  always #50 mclk = ~mclk;
  always #3 lclk = ~lclk;
  // The interrupt line is pulled up when nobody pulls it low.
  assign sirq_pin = serirq_oe_n ? 1'b1 : serirq_out;

  serirq_req_ctrl i_serirq_req_ctrl (.mclk(mclk), .nrst(nrst), .bus(bus),
    .rdata(rdata), .ch2_out_full(ch2_out_full), .uart_irq(uart_irq),
    .two_way_reg_mode(two_way_reg_mode), .lpc_hw_rst_n(lpc_hw_rst_n),
    .lpc_sw_rst(lpc_sw_rst), .ch3_out_data(ch3_out_data),
    .ch3_out_full_a(ch3_out_full_a), .status3_user_mode(status3_user_mode),
    .frame_req(frame_req), .lclk(lclk), .lrst_n(lrst_n),
    .host_rd_ch3(host_rd_ch3), .frame_active(frame_active),
    .frame_num(frame_num), .serirq_out(serirq_out),
    .serirq_oe_n(serirq_oe_n));
  lpc_host_model host (.lclk(lclk), .sirq_pin(sirq_pin),
    .host_rd_ch3(host_rd_ch3), .frame_active(frame_active),
    .frame_num(frame_num));

  // ****************************************
  // Model and tasks
  // ****************************************
  // Requests expected from the model state and the live inputs.
  function automatic logic [15:0] exp_req();
    logic [15:0] x;
    logic [3:0]  e;
    x = {mr[3][7:5], 4'h0, mr[3][4:3], 1'b0, mr[3][2:0], 3'h0};
    if (uart_irq && mr[2][3:0] != 4'h0) x[mr[2][3:0]] = 1'b1;
    e = mr[0][7:4] & {4{mr[1][7] | full3}};
    e = e | (mr[0][3:0] & {4{mr[6][7] | ch2_out_full}});
    return x | {4'h0, e[3:1], 2'h0, e[0], 6'h0};
  endfunction

  // Polarity select of every frame; frame 0 has none.
  function automatic logic [15:0] pol();
    return {mr[4][7:5], mr[5][1], mr[5][6:4], mr[4][4:3], mr[5][3],
            mr[4][2:0], mr[5][2], mr[5][0], 1'b0};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Each strobe is followed by one idle cycle, so no signal moves twice.
  task automatic wm(input logic [3:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
    if (a == 4'h0) d = d & (mr[0] | arm);
    if (a == 4'h0) arm = 8'h00;
    if (a < 4'h8) mr[a] = d;
    if (a == 4'h7) full3 = 1'b1;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rm(input logic [3:0] a);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 q = rdata;
    @(posedge mclk);
    e8 = a[3] ? 8'h00 : mr[a[2:0]];
    if (a == 4'h8)
      e8 = {4'h0, mr[5][7] & !two_way_reg_mode, lpcr, ch2_out_full, full3};
    chk("rdata", {8'h00, e8}, {8'h00, q});
    if (a == 4'h0) arm = ~mr[0];
  endtask

  task automatic host_rd();
    host.host_read();
    @(posedge mclk);
    if (full3 && !mr[1][7]) mr[0][7:4] = 4'h0;
    full3 = 1'b0;
  endtask

  // Let the crossings land, then compare the register-side outputs and the status byte with the model; the pins are checked in pins().
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
    chk("frame_req", exp_req(), frame_req);
    chk("flag", {15'h0, full3}, {15'h0, ch3_out_full_a});
    chk("user", {15'h0, mr[5][7] & !two_way_reg_mode},
        {15'h0, status3_user_mode});
    chk("data", {8'h00, mr[7]}, {8'h00, ch3_out_data});
    @(posedge mclk);
    rm(4'h8);
  endtask

  task automatic pins();
    host.scan();
    chk("pins", exp_req() ^ pol(), host.seen);
    @(posedge mclk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset, arming, random traffic, then both LPC resets.
  initial
  begin
    repeat (5) @(posedge mclk);
    nrst   <= 1'b1;
    lrst_n <= 1'b1;
    @(posedge mclk);
    for (int a = 15; a >= 0; a--)
      rm(4'(a));
    wm(4'h0, 8'h00);
    wm(4'h0, 8'hFF);
    rm(4'h0);
    wm(4'h0, 8'hFF);
    rm(4'h0);
    settle();
    for (int i = 0; i < 48; i++)
    begin
      r = $random(seed);
      if (ch2_out_full && !r[0] && !mr[6][7]) mr[0][3:0] = 4'h0;
      ch2_out_full     <= r[0];
      uart_irq         <= r[1];
      two_way_reg_mode <= r[2];
      wm(4'h1, {r[8], 7'h00});
      wm(4'h6, {r[9], 7'h00});
      wm(4'h2, {4'h0, 4'(i)});
      wm(4'h3, r[23:16]);
      wm(4'h4, r[31:24]);
      wm(4'h5, 8'($random(seed)));
      if (r[5]) wm(4'h7, r[15:8]);
      if (!r[6]) rm(4'h0);
      wm(4'h0, 8'($random(seed)));
      if (r[7]) host_rd();
      settle();
      if (i % 3 == 0) pins();
    end
    for (int k = 0; k < 2; k++)
    begin
      wm(4'h7, 8'h5A);
      rm(4'h0);
      wm(4'h0, 8'hFF);
      // First pass pulls the hardware reset, second the software reset.
      lpc_hw_rst_n <= k[0];
      lpc_sw_rst   <= k[0];
      mr[0] = 8'h00;
      arm   = 8'h00;
      full3 = 1'b0;
      lpcr  = 1'b1;
      repeat (3) @(posedge mclk);
      rm(4'h8);
      lpc_hw_rst_n <= 1'b1;
      lpc_sw_rst   <= 1'b0;
      lpcr  = 1'b0;
      settle();
      pins();
    end
    finish_test();
  end

  // A hang ends the run as a mismatch.
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
